// ### nipet_params.svh
// Purpose: Register addresses, field positions, reset values and codes.
// Assumes: Included by those files of the nested interrupt block that use its constants.
// Notes: Definitions only; nothing here makes logic.
`ifndef NIPET_PARAMS_SVH
`define NIPET_PARAMS_SVH

// Register byte addresses.
`define NIPET_A_PRIO0 32'hFFFF0020
`define NIPET_A_NEST 32'hFFFF0030
`define NIPET_A_TRIG 32'hFFFF0034
`define NIPET_A_EDGECLR 32'hFFFF0038
`define NIPET_A_NISL 32'hFFFF003C
`define NIPET_A_FVEC 32'hFFFF011C
`define NIPET_A_FISL 32'hFFFF013C
`define NIPET_A_NEN 32'hFFFF0200
`define NIPET_A_FEN 32'hFFFF0204
`define NIPET_A_BASE 32'hFFFF0208
`define NIPET_A_NVEC 32'hFFFF020C
`define NIPET_A_EVSTAT 32'hFFFF0210
`define NIPET_A_EVMASK 32'hFFFF0214
`define NIPET_A_STEP 32'h00000004

// Field positions.
`define NIPET_NEST_NORM_BIT 0
`define NIPET_NEST_FAST_BIT 1
`define NIPET_EDGE_CLR_LSB 19
`define NIPET_VEC_SRC_LSB 2
`define NIPET_VEC_BASE_LSB 7
`define NIPET_PRIO_STRIDE 4
`define NIPET_PRIO_PER_REG 8
`define NIPET_PRIO_REGS 4

// Event status bits.
`define NIPET_EV_IRQ 0
`define NIPET_EV_FIQ 1
`define NIPET_EV_EDGE 2
`define NIPET_EV_W 3

// Trigger selector codes.
`define NIPET_SEL_HIGH 2'h0
`define NIPET_SEL_LOW 2'h1
`define NIPET_SEL_RISE 2'h2
`define NIPET_SEL_FALL 2'h3

// Reset value and the empty in-service ceiling.
`define NIPET_RST_ZERO 32'h00000000
`define NIPET_CEIL_NONE 4'h8

`endif

// ### nipet_pkg.sv
// Purpose: Shared types of the nested interrupt block.
// Assumes: Constants come from nipet_params.svh.
// Notes: Nothing in here is meant to be imported.
package nipet_pkg;

  // One register bus request as the master presents it.
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } nipet_bus_req_t;

  // Result of the priority search over all sources.
  typedef struct packed {
    logic found;
    logic [4:0] src;
    logic [2:0] lvl;
  } nipet_pick_t;

endpackage

// ### nipet_ext_line.sv
// Purpose: One external interrupt line with its trigger selector.
// Assumes: pin is asynchronous; sel and edgeClr come from mclk logic.
// Notes: Level modes follow the pin; edge modes latch until cleared.
`timescale 1ns/1ns
`include "nipet_params.svh"
module nipet_ext_line (
  input wire logic mclk,
  input wire logic rst,
  input wire logic pin,
  input wire logic [1:0] sel,
  input wire logic edgeClr,
  output logic req,
  output logic edgeSeen
);

  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic pend_reg;
  logic pend_next;
  logic isEdge;
  logic levelHit;

  // Two-stage synchroniser, then one more stage for edge detection.
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // Decode the selector into a level match or an edge event.
  always_comb begin
    isEdge = sel[1];
    levelHit = (sel == `NIPET_SEL_HIGH) ? sync2_reg : ~sync2_reg;
    case (sel)
      `NIPET_SEL_RISE: edgeSeen = sync2_reg & ~prev_reg;
      `NIPET_SEL_FALL: edgeSeen = ~sync2_reg & prev_reg;
      default: edgeSeen = 1'b0;
    endcase
  end

  // Pending edge holds until cleared; a new edge beats a clear.
  always_comb begin
    pend_next = pend_reg;
    if (edgeClr) begin
      pend_next = 1'b0;
    end
    if (edgeSeen) begin
      pend_next = 1'b1;
    end
    if (!isEdge) begin
      pend_next = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pend_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
    end
  end

  // Level modes ignore the clear and follow the pin.
  assign req = isEdge ? pend_reg : levelHit;

endmodule

// ### nipet_isl.sv
// Purpose: In-service level register for one interrupt type.
// Assumes: setStb and clrStb are one-cycle strobes on mclk.
// Notes: Any write clears only the highest-priority set bit.
`timescale 1ns/1ns
`include "nipet_params.svh"
module nipet_isl #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic setStb,
  input wire logic [2:0] setIdx,
  input wire logic clrStb,
  output logic [W-1:0] level,
  output logic [3:0] ceil
);

  logic [W-1:0] level_reg;
  logic [W-1:0] level_next;

  // Clear first, then set, so a set in the same cycle is kept.
  always_comb begin
    level_next = level_reg;
    if (clrStb) begin
      level_next = level_reg & (level_reg - W'(1));
    end
    if (setStb) begin
      level_next = level_next | (W'(1) << setIdx);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      level_reg <= W'(`NIPET_RST_ZERO);
    end else begin
      level_reg <= level_next;
    end
  end

  // Lowest set index is the level at and below which all is blocked.
  always_comb begin
    ceil = `NIPET_CEIL_NONE;
    for (int i = W - 1; i >= 0; i--) begin
      if (level_reg[i]) begin
        ceil = 4'(i);
      end
    end
  end

  assign level = level_reg;

endmodule

// ### nipet_top.sv
// Purpose: Nesting, priority and external trigger logic of the
//   vectored interrupt controller, with its register slave.
// Assumes: One clock mclk at 20 MHz, synchronous active-high rst,
//   peripheral requests on mclk, external pins asynchronous.
// Notes: Read data appear in the cycle after the read strobe.
// How it works
// - Nest control bit 0 turns on nesting and priority for normal ones.
// - Nest control bit 1 turns on nesting and priority for fast ones.
// - Both bits clear: no levels used, fast beats normal.
// - Normal vector read with nesting on sets in-service bit of level.
// - Fast vector read with nesting on sets fast in-service bit of level.
// - A set in-service bit blocks that priority and every lower one.
// - Each in-service write clears only its lowest-index set bit.
// - Fast vector: zero, base at 22:7, source at 6:2, zero 1:0.
// - Six external lines, each level or edge triggered on its own.
// - Selector 11 falling, 10 rising, 01 low level, 00 high level.
// - Line n selector at bits 2n+1:2n; bits 31:12 read as zero.
// - An edge request stays pending until its clear bit is written.
// - Edge clear bits start at bit 19 for line 0.
// - Every source has a programmable three-bit priority level.
`timescale 1ns/1ns
`include "nipet_params.svh"
module nipet_top #(
  parameter int NSRC = 28,
  parameter int NEXT = 6,
  parameter int EXT_BASE = 19,
  parameter int SRC_W = 5,
  parameter int BASE_W = 16,
  parameter int LVL_W = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input nipet_pkg::nipet_bus_req_t busReq,
  output logic [31:0] busRdata,
  input wire logic [NSRC-1:0] periphReq,
  input wire logic [NEXT-1:0] extPin,
  output logic irqOut,
  output logic fiqOut,
  output logic eventIrq
);

  logic [1:0] nest_reg;
  logic [2*NEXT-1:0] trig_reg;
  logic [NSRC-1:0] normEn_reg;
  logic [NSRC-1:0] fastEn_reg;
  logic [2:0] prio_reg [NSRC];
  logic [BASE_W-1:0] base_reg;
  logic [`NIPET_EV_W-1:0] evStat_reg;
  logic [`NIPET_EV_W-1:0] evStat_next;
  logic [`NIPET_EV_W-1:0] evMask_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic irq_reg;
  logic irq_next;
  logic fiq_reg;
  logic fiq_next;
  logic eventIrq_reg;

  logic wrNest;
  logic wrTrig;
  logic wrEdgeClr;
  logic wrNisl;
  logic wrFisl;
  logic rdNvec;
  logic rdFvec;
  logic normNest;
  logic fastNest;
  logic [NEXT-1:0] extReq;
  logic [NEXT-1:0] extEdge;
  logic [NEXT-1:0] extClr;
  logic [NSRC-1:0] srcAll;
  logic [LVL_W-1:0] nislLevel;
  logic [LVL_W-1:0] fislLevel;
  logic [3:0] nislCeil;
  logic [3:0] fislCeil;
  logic [31:0] normVec;
  logic [31:0] fastVec;
  logic [`NIPET_EV_W-1:0] evSet;
  nipet_pkg::nipet_pick_t normPick;
  nipet_pkg::nipet_pick_t fastPick;

  // Address decode of the strobes that have side effects.
  assign wrNest = busReq.wr && (busReq.addr == `NIPET_A_NEST);
  assign wrTrig = busReq.wr && (busReq.addr == `NIPET_A_TRIG);
  assign wrEdgeClr = busReq.wr && (busReq.addr == `NIPET_A_EDGECLR);
  assign wrNisl = busReq.wr && (busReq.addr == `NIPET_A_NISL);
  assign wrFisl = busReq.wr && (busReq.addr == `NIPET_A_FISL);
  assign rdNvec = busReq.rd && (busReq.addr == `NIPET_A_NVEC);
  assign rdFvec = busReq.rd && (busReq.addr == `NIPET_A_FVEC);

  // Nesting enables; when off, levels are not looked at at all.
  assign normNest = nest_reg[`NIPET_NEST_NORM_BIT];
  assign fastNest = nest_reg[`NIPET_NEST_FAST_BIT];

  // Nest control and trigger configuration registers.
  always_ff @(posedge mclk) begin
    if (rst) begin
      nest_reg <= 2'(`NIPET_RST_ZERO);
      trig_reg <= (2*NEXT)'(`NIPET_RST_ZERO);
    end else begin
      if (wrNest) begin
        nest_reg <= busReq.wdata[1:0];
      end
      if (wrTrig) begin
        trig_reg <= busReq.wdata[2*NEXT-1:0];
      end
    end
  end

  // Source enables and the vector base.
  always_ff @(posedge mclk) begin
    if (rst) begin
      normEn_reg <= NSRC'(`NIPET_RST_ZERO);
      fastEn_reg <= NSRC'(`NIPET_RST_ZERO);
      base_reg <= BASE_W'(`NIPET_RST_ZERO);
    end else begin
      if (busReq.wr && (busReq.addr == `NIPET_A_NEN)) begin
        normEn_reg <= busReq.wdata[NSRC-1:0];
      end
      if (busReq.wr && (busReq.addr == `NIPET_A_FEN)) begin
        fastEn_reg <= busReq.wdata[NSRC-1:0];
      end
      if (busReq.wr && (busReq.addr == `NIPET_A_BASE)) begin
        base_reg <= busReq.wdata[BASE_W-1:0];
      end
    end
  end

  // Priority levels: source s sits in nibble s mod 8 of word s div 8.
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int s = 0; s < NSRC; s++) begin
        prio_reg[s] <= 3'(`NIPET_RST_ZERO);
      end
    end else begin
      for (int s = 0; s < NSRC; s++) begin
        if (busReq.wr && (busReq.addr == `NIPET_A_PRIO0 +
            32'(s / `NIPET_PRIO_PER_REG) * `NIPET_A_STEP)) begin
          prio_reg[s] <= busReq.wdata[(s % `NIPET_PRIO_PER_REG) *
            `NIPET_PRIO_STRIDE +: 3];
        end
      end
    end
  end

  // External lines; edge clear bit of line n is bit 19 + n.
  for (genvar n = 0; n < NEXT; n++) begin : gExt
    assign extClr[n] = wrEdgeClr &&
      busReq.wdata[`NIPET_EDGE_CLR_LSB + n];
    nipet_ext_line uLine (
      .mclk(mclk),
      .rst(rst),
      .pin(extPin[n]),
      .sel(trig_reg[2*n +: 2]),
      .edgeClr(extClr[n]),
      .req(extReq[n]),
      .edgeSeen(extEdge[n])
    );
  end

  // External requests join the peripheral requests at their numbers.
  assign srcAll = periphReq |
    ({{(NSRC-NEXT){1'b0}}, extReq} << EXT_BASE);

  // In-service levels; reading a vector with nesting on marks a level.
  nipet_isl #(
    .W(LVL_W)
  ) uNormIsl (
    .mclk(mclk),
    .rst(rst),
    .setStb(rdNvec && normNest && normPick.found),
    .setIdx(normPick.lvl),
    .clrStb(wrNisl),
    .level(nislLevel),
    .ceil(nislCeil)
  );

  nipet_isl #(
    .W(LVL_W)
  ) uFastIsl (
    .mclk(mclk),
    .rst(rst),
    .setStb(rdFvec && fastNest && fastPick.found),
    .setIdx(fastPick.lvl),
    .clrStb(wrFisl),
    .level(fislLevel),
    .ceil(fislCeil)
  );

  // Search for the winning source; ties go to the lower number.
  function automatic nipet_pkg::nipet_pick_t pick(
    input logic [NSRC-1:0] act,
    input logic useLvl,
    input logic [3:0] ceil
  );
    nipet_pkg::nipet_pick_t best;
    logic ok;
    best = '0;
    for (int i = 0; i < NSRC; i++) begin
      ok = act[i] && (!useLvl || ({1'b0, prio_reg[i]} < ceil));
      if (ok && (!best.found || (useLvl && prio_reg[i] < best.lvl))) begin
        best.found = 1'b1;
        best.src = SRC_W'(i);
        best.lvl = prio_reg[i];
      end
    end
    return best;
  endfunction

  // Without nesting the levels play no part in the choice.
  always_comb begin
    normPick = pick(srcAll & normEn_reg, normNest, nislCeil);
    fastPick = pick(srcAll & fastEn_reg, fastNest, fislCeil);
  end

  // Vector words: base, then the winning source number.
  always_comb begin
    fastVec = '0;
    fastVec[`NIPET_VEC_BASE_LSB +: BASE_W] = base_reg;
    fastVec[`NIPET_VEC_SRC_LSB +: SRC_W] = fastPick.src;
    normVec = '0;
    normVec[`NIPET_VEC_BASE_LSB +: BASE_W] = base_reg;
    normVec[`NIPET_VEC_SRC_LSB +: SRC_W] = normPick.src;
  end

  // Core outputs; in the default state a fast request holds off normal.
  always_comb begin
    fiq_next = fastPick.found;
    irq_next = normPick.found &&
      !((nest_reg == 2'(`NIPET_RST_ZERO)) && fastPick.found);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_reg <= 1'b0;
      fiq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
      fiq_reg <= fiq_next;
    end
  end

  // Sticky events: new normal, new fast, captured external edge.
  always_comb begin
    evSet = '0;
    evSet[`NIPET_EV_IRQ] = irq_next && !irq_reg;
    evSet[`NIPET_EV_FIQ] = fiq_next && !fiq_reg;
    evSet[`NIPET_EV_EDGE] = |extEdge;
    evStat_next = evStat_reg;
    if (busReq.wr && (busReq.addr == `NIPET_A_EVSTAT)) begin
      evStat_next = evStat_reg & ~busReq.wdata[`NIPET_EV_W-1:0];
    end
    // Setting after clearing keeps an event that lands on a clear.
    evStat_next = evStat_next | evSet;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      evStat_reg <= `NIPET_EV_W'(`NIPET_RST_ZERO);
      evMask_reg <= `NIPET_EV_W'(`NIPET_RST_ZERO);
      eventIrq_reg <= 1'b0;
    end else begin
      evStat_reg <= evStat_next;
      if (busReq.wr && (busReq.addr == `NIPET_A_EVMASK)) begin
        evMask_reg <= busReq.wdata[`NIPET_EV_W-1:0];
      end
      eventIrq_reg <= |(evStat_next & evMask_reg);
    end
  end

  // Read multiplexer; unmapped and write-only words read as zero.
  always_comb begin
    rdata_next = `NIPET_RST_ZERO;
    if (busReq.rd) begin
      for (int k = 0; k < `NIPET_PRIO_REGS; k++) begin
        if (busReq.addr == `NIPET_A_PRIO0 + 32'(k) * `NIPET_A_STEP) begin
          for (int j = 0; j < `NIPET_PRIO_PER_REG; j++) begin
            if (k * `NIPET_PRIO_PER_REG + j < NSRC) begin
              rdata_next[j * `NIPET_PRIO_STRIDE +: 3] =
                prio_reg[k * `NIPET_PRIO_PER_REG + j];
            end
          end
        end
      end
      case (busReq.addr)
        `NIPET_A_NEST: rdata_next = 32'(nest_reg);
        `NIPET_A_TRIG: rdata_next = 32'(trig_reg);
        `NIPET_A_NISL: rdata_next = 32'(nislLevel);
        `NIPET_A_FISL: rdata_next = 32'(fislLevel);
        `NIPET_A_FVEC: rdata_next = fastVec;
        `NIPET_A_NVEC: rdata_next = normVec;
        `NIPET_A_NEN: rdata_next = 32'(normEn_reg);
        `NIPET_A_FEN: rdata_next = 32'(fastEn_reg);
        `NIPET_A_BASE: rdata_next = 32'(base_reg);
        `NIPET_A_EVSTAT: rdata_next = 32'(evStat_reg);
        `NIPET_A_EVMASK: rdata_next = 32'(evMask_reg);
        default: rdata_next = rdata_next;
      endcase
    end
  end

  // Read data is held for the single cycle after the strobe only.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_reg <= `NIPET_RST_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign busRdata = rdata_reg;
  assign irqOut = irq_reg;
  assign fiqOut = fiq_reg;
  assign eventIrq = eventIrq_reg;

endmodule

// ### nipet_properties.sv
// Purpose: Port-level properties of the nested interrupt block.
// Assumes: Sees only nipet_top ports; one clock, synchronous reset.
// Notes: A few registers are shadowed from bus writes to judge outputs.
`timescale 1ns/1ns
`include "nipet_params.svh"
module nipet_properties #(
  parameter int NSRC = 28,
  parameter int NEXT = 6
) (
  input wire logic mclk,
  input wire logic rst,
  input nipet_pkg::nipet_bus_req_t busReq,
  input wire logic [31:0] busRdata,
  input wire logic [NSRC-1:0] periphReq,
  input wire logic [NEXT-1:0] extPin,
  input wire logic irqOut,
  input wire logic fiqOut,
  input wire logic eventIrq
);
  logic [1:0] nestReg;
  logic [NSRC-1:0] nenReg;
  logic [NSRC-1:0] fenReg;
  logic [2:0] maskReg;

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // Shadows follow writes, so a write at an edge counts from that edge.
  always_ff @(posedge mclk) begin
    if (rst) begin
      nestReg <= 2'h0;
      nenReg <= '0;
      fenReg <= '0;
      maskReg <= 3'h0;
    end else if (busReq.wr) begin
      if (busReq.addr == `NIPET_A_NEST) nestReg <= busReq.wdata[1:0];
      if (busReq.addr == `NIPET_A_NEN) nenReg <= busReq.wdata[NSRC-1:0];
      if (busReq.addr == `NIPET_A_FEN) fenReg <= busReq.wdata[NSRC-1:0];
      if (busReq.addr == `NIPET_A_EVMASK) maskReg <= busReq.wdata[2:0];
    end
  end

  // A read strobe aimed at one register.
  sequence s_rd(logic [31:0] a);
    busReq.rd && busReq.addr == a;
  endsequence

  a_rdata_idle: assert property (
    !busReq.rd |=> busRdata == 32'h00000000)
    else $error("read data not zero outside a read");
  a_fvec_zero: assert property (
    s_rd(`NIPET_A_FVEC) |=> busRdata[31:23] == 9'h000 &&
      busRdata[1:0] == 2'h0)
    else $error("fast vector reserved bits not zero");
  a_trig_reserved: assert property (
    s_rd(`NIPET_A_TRIG) |=> busRdata[31:12] == 20'h00000)
    else $error("trigger config reserved bits not zero");
  a_nisl_reserved: assert property (
    s_rd(`NIPET_A_NISL) |=> busRdata[31:8] == 24'h000000)
    else $error("normal in-service upper bits not zero");
  a_fisl_reserved: assert property (
    s_rd(`NIPET_A_FISL) |=> busRdata[31:8] == 24'h000000)
    else $error("fast in-service upper bits not zero");
  a_fiq_beats_irq: assert property (
    nestReg == 2'h0 && $past(nestReg) == 2'h0 && fiqOut |-> !irqOut)
    else $error("normal request shown beside a fast one");
  a_fiq_follows: assert property (
    !nestReg[1] && |(periphReq & fenReg) |=> fiqOut)
    else $error("eligible fast source did not raise fast output");
  a_irq_follows: assert property (
    nestReg == 2'h0 && fenReg == '0 && |(periphReq & nenReg) |=> irqOut)
    else $error("eligible normal source did not raise normal output");
  a_event_masked: assert property (
    maskReg == 3'h0 && !(busReq.wr && busReq.addr == `NIPET_A_EVMASK)
      |=> !eventIrq)
    else $error("event interrupt high with every status bit masked");
endmodule

// ### nipet_far_model.sv
// Purpose: Far side: external pins and the core's fast interrupt input.
// Assumes: Pin levels are commanded by the bench on mclk.
// Notes: Pins are driven by a push-pull driver, so no level floats.
`timescale 1ns/1ns
module nipet_far_model (
  input wire logic mclk,
  input wire logic [5:0] pinCmd,
  input wire logic fiqOut,
  output logic [5:0] extPin,
  output int fiqEntries
);
  logic fiqPrev = 1'b0;
  int entries = 0;

  // One process owns the count, so the port has a single driver.
  assign fiqEntries = entries;

  // Pins move one clock after the command, like a registered driver.
  always @(posedge mclk) begin
    extPin <= pinCmd;
  end

  // The core enters its fast handler once per rising request.
  always @(posedge mclk) begin
    fiqPrev <= fiqOut;
    if (fiqOut && !fiqPrev) entries <= entries + 1;
  end
endmodule

// ### nested_irq_priority_ext_trigger_test.sv
// Purpose: Self-checking bench for the nested interrupt block.
// Assumes: 20 MHz mclk; registers reached through the plain port.
// Notes: Waits after pin moves cover the two-stage synchroniser.
`timescale 1ns/1ns
`include "nipet_params.svh"
module nested_irq_priority_ext_trigger_test;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  nipet_pkg::nipet_bus_req_t busReq = '0;
  logic [31:0] busRdata;
  logic [27:0] periphReq = 28'h0000000;
  logic [5:0] pinCmd = 6'h00;
  logic [5:0] extPin;
  logic irqOut;
  logic fiqOut;
  logic eventIrq;
  int fiqEntries;
  int badCount = 0;
  int nCompared = 0;

  // Half of the 50 ns period.
  always #25 mclk = ~mclk;

  nipet_top dut (.mclk(mclk), .rst(rst), .busReq(busReq),
    .busRdata(busRdata), .periphReq(periphReq), .extPin(extPin),
    .irqOut(irqOut), .fiqOut(fiqOut), .eventIrq(eventIrq));
  nipet_far_model far (.mclk(mclk), .pinCmd(pinCmd), .fiqOut(fiqOut),
    .extPin(extPin), .fiqEntries(fiqEntries));

  task automatic conclude;
    $display("compared %0d mismatched %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Case equality, so an unknown never passes.
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    nCompared++;
    if (g !== e) begin
      badCount++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    busReq.addr <= a;
    busReq.wdata <= d;
    busReq.wr <= 1'b1;
    @(posedge mclk);
    busReq.wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe, so look there.
  task automatic rdc(input string nm, input logic [31:0] a,
    input logic [31:0] e);
    @(posedge mclk);
    busReq.addr <= a;
    busReq.rd <= 1'b1;
    @(posedge mclk);
    busReq.rd <= 1'b0;
    #1;
    chk(nm, e, busRdata);
  endtask

  task automatic fq(input string nm, input logic e);
    chk(nm, {31'h0, e}, {31'h0, fiqOut});
  endtask

  task automatic pin(input logic on);
    @(posedge mclk) pinCmd <= on ? 6'h3F : 6'h00;
    wt(6);
  endtask

  task automatic clrE(input int n);
    wr(`NIPET_A_EDGECLR, 32'h1 << (19 + n));
    wt(3);
  endtask

  task automatic t_regs;
    rdc("nest", `NIPET_A_NEST, 32'h0);
    rdc("fisl", `NIPET_A_FISL, 32'h0);
    rdc("nisl", `NIPET_A_NISL, 32'h0);
    wr(`NIPET_A_TRIG, 32'hFFFFFFFF);
    rdc("trig", `NIPET_A_TRIG, 32'h00000FFF);
    wr(`NIPET_A_NEST, 32'hFFFFFFFF);
    rdc("nest", `NIPET_A_NEST, 32'h00000003);
    wr(`NIPET_A_FVEC, 32'hFFFFFFFF);
    rdc("fvec", `NIPET_A_FVEC, 32'h0);
    rdc("hole", 32'hFFFF0100, 32'h0);
    wr(`NIPET_A_PRIO0 + 32'h0000000C, 32'hFFFFFFFF);
    rdc("prio3", `NIPET_A_PRIO0 + 32'h0000000C, 32'h00007777);
    wr(`NIPET_A_PRIO0 + 32'h0000000C, 32'h0);
    wr(`NIPET_A_EDGECLR, 32'hFFFFFFFF);
    rdc("edgeclr", `NIPET_A_EDGECLR, 32'h0);
    wr(`NIPET_A_NEST, 32'h0);
    wr(`NIPET_A_TRIG, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_fiq;
    int e0;
    e0 = fiqEntries;
    wr(`NIPET_A_BASE, 32'h0000ABCD);
    rdc("base", `NIPET_A_BASE, 32'h0000ABCD);
    wr(`NIPET_A_NEN, 32'h00000004);
    @(posedge mclk) periphReq <= 28'h0000004;
    wt(2);
    chk("irq", 32'h1, {31'h0, irqOut});
    wr(`NIPET_A_FEN, 32'h00000008);
    @(posedge mclk) periphReq <= 28'h000000C;
    wt(2);
    fq("fiq", 1'b1);
    chk("irq", 32'h0, {31'h0, irqOut});
    rdc("fvec", `NIPET_A_FVEC, {9'h000, 16'hABCD, 5'h03, 2'h0});
    rdc("fisl", `NIPET_A_FISL, 32'h0);
    wr(`NIPET_A_PRIO0, 32'h00005000);
    rdc("prio0", `NIPET_A_PRIO0, 32'h00005000);
    wr(`NIPET_A_NEST, 32'h00000002);
    rdc("fvec", `NIPET_A_FVEC, {9'h000, 16'hABCD, 5'h03, 2'h0});
    rdc("fisl", `NIPET_A_FISL, 32'h00000020);
    wt(1);
    fq("fiq blocked", 1'b0);
    wr(`NIPET_A_FISL, 32'hFFFFFFFF);
    wt(2);
    fq("fiq again", 1'b1);
    chk("entries", 32'h2, 32'(fiqEntries - e0));
    @(posedge mclk) periphReq <= 28'h0000000;
    wr(`NIPET_A_NEST, 32'h0);
    wr(`NIPET_A_FEN, 32'h0);
    wr(`NIPET_A_PRIO0, 32'h0);
    $display("test fiq done");
  endtask

  task automatic t_isl;
    wr(`NIPET_A_NEST, 32'h00000001);
    wr(`NIPET_A_NEN, 32'h00000030);
    rdc("nen", `NIPET_A_NEN, 32'h00000030);
    wr(`NIPET_A_PRIO0, 32'h00030000);
    @(posedge mclk) periphReq <= 28'h0000010;
    wt(2);
    rdc("nvec", `NIPET_A_NVEC, {9'h000, 16'hABCD, 5'h04, 2'h0});
    rdc("nisl", `NIPET_A_NISL, 32'h00000008);
    wt(1);
    chk("irq blocked", 32'h0, {31'h0, irqOut});
    @(posedge mclk) periphReq <= 28'h0000030;
    wt(2);
    chk("irq nested", 32'h1, {31'h0, irqOut});
    rdc("nvec", `NIPET_A_NVEC, {9'h000, 16'hABCD, 5'h05, 2'h0});
    rdc("nisl", `NIPET_A_NISL, 32'h00000009);
    wr(`NIPET_A_NISL, 32'h000000FF);
    rdc("nisl", `NIPET_A_NISL, 32'h00000008);
    wr(`NIPET_A_NISL, 32'h000000FF);
    rdc("nisl", `NIPET_A_NISL, 32'h00000000);
    @(posedge mclk) periphReq <= 28'h0000000;
    wr(`NIPET_A_NEST, 32'h0);
    wr(`NIPET_A_NEN, 32'h0);
    $display("test isl done");
  endtask

  task automatic t_event;
    wr(`NIPET_A_EVSTAT, 32'h00000007);
    wr(`NIPET_A_EVMASK, 32'h00000002);
    wr(`NIPET_A_FEN, 32'h00000008);
    @(posedge mclk) periphReq <= 28'h0000008;
    wt(2);
    chk("event", 32'h1, {31'h0, eventIrq});
    rdc("evstat", `NIPET_A_EVSTAT, 32'h00000002);
    rdc("evmask", `NIPET_A_EVMASK, 32'h00000002);
    wr(`NIPET_A_EVMASK, 32'h00000001);
    wt(1);
    chk("event masked", 32'h0, {31'h0, eventIrq});
    wr(`NIPET_A_EVSTAT, 32'h00000002);
    wr(`NIPET_A_EVMASK, 32'h00000002);
    wt(1);
    chk("event cleared", 32'h0, {31'h0, eventIrq});
    @(posedge mclk) periphReq <= 28'h0000000;
    wr(`NIPET_A_FEN, 32'h0);
    $display("test event done");
  endtask

  // Lines 0 and 5 through all four selector codes; idle level is c[0].
  task automatic t_ext;
    int n;
    logic [1:0] c;
    for (int k = 0; k < 2; k++) begin
      n = k * 5;
      wr(`NIPET_A_FEN, 32'h1 << (19 + n));
      rdc("fen", `NIPET_A_FEN, 32'h1 << (19 + n));
      for (int j = 0; j < 4; j++) begin
        c = 2'(j);
        pin(c[0]);
        wr(`NIPET_A_TRIG, 32'(c) << (2 * n));
        wt(6);
        clrE(n);
        fq("ext quiet", 1'b0);
        pin(!c[0]);
        fq("ext fired", 1'b1);
        clrE(n);
        fq("ext after clear", !c[1]);
        pin(c[0]);
        fq("ext released", 1'b0);
        pin(!c[0]);
        pin(c[0]);
        fq("ext pending", c[1]);
        clrE(n);
        fq("ext cleared", 1'b0);
      end
    end
    wr(`NIPET_A_FEN, 32'h0);
    // Fast rises and captured edges were both seen, no normal rise.
    rdc("evstat edge", `NIPET_A_EVSTAT, 32'h00000006);
    $display("test ext done");
  endtask

  // Main sequence after the 16-cycle reset.
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_regs;
    t_fiq;
    t_isl;
    t_event;
    t_ext;
    conclude;
  end

  // Watchdog: the whole run needs well under 2000 cycles.
  initial begin
    repeat (5000) @(posedge mclk);
    badCount++;
    $display("BAD watchdog expected finish seen hang");
    conclude;
  end
endmodule

bind nipet_top nipet_properties #(.NSRC(NSRC), .NEXT(NEXT)) props (
  .mclk(mclk), .rst(rst), .busReq(busReq), .busRdata(busRdata),
  .periphReq(periphReq), .extPin(extPin), .irqOut(irqOut),
  .fiqOut(fiqOut), .eventIrq(eventIrq));
